/* logic/fp_status_control_register.sv */
// Floating-point status/control word: compare flags, modes, vector control, exceptions
`timescale 1ns/1ps
module fp_status_control_register (
    input  wire logic                             clk_sys,
    input  wire logic                             srst,
    input  wire logic                             cp_enable,
    input  wire logic                             privileged,
    input  wire fp_status_control_pkg::xfer_req_t xfer_req,
    input  wire fp_status_control_pkg::cmp_event_t cmp_event,
    input  wire logic                             exc_valid,
    input  wire fp_status_control_pkg::fp_exc_t   exc_flags,
    output logic                                  xfer_done,
    output logic                                  undef_trap,
    output logic [31:0]                           rdata,
    output fp_status_control_pkg::fp_ctrl_t       fp_ctrl
);
    // ==========================================================
    // Access decode
    // ==========================================================
    logic [31:0] fp_status_control_ff;
    logic [31:0] nxt_fp_status_control;
    logic        xfer_done_ff;
    logic        undef_trap_ff;
    logic [31:0] rdata_ff;
    fp_status_control_pkg::fp_ctrl_t fp_ctrl_ff;

    // Privilege level is deliberately not consulted
    wire logic hit      = xfer_req.valid && xfer_req.sel == fp_status_control_pkg::SEL_STATUS_CONTROL;
    wire logic granted  = hit && cp_enable;
    wire logic refused  = hit && !cp_enable;
    wire logic wr_go    = granted && xfer_req.write;
    wire logic rd_go    = granted && !xfer_req.write;

    // ==========================================================
    // Comparison flags
    // ==========================================================
    function automatic logic [3:0] cmp_flags(input fp_status_control_pkg::cmp_result_t r);
        unique case (r)
            fp_status_control_pkg::cmp_less:      cmp_flags = 4'h8;
            fp_status_control_pkg::cmp_equal:     cmp_flags = 4'h6;
            fp_status_control_pkg::cmp_greater:   cmp_flags = 4'h2;
            fp_status_control_pkg::cmp_unordered: cmp_flags = 4'h3;
        endcase
    endfunction : cmp_flags

    wire logic [3:0] new_nzcv = cmp_flags(cmp_event.result);

    // ==========================================================
    // Next value: write, then compare and sticky events override
    // ==========================================================
    wire logic [5:0] exc_vec = exc_valid ? exc_flags : 6'h00;
    wire logic [31:0] sticky_set = {24'h000000, exc_vec[5], 2'h0, exc_vec[4:0]};

    always_comb begin
        nxt_fp_status_control = fp_status_control_ff;
        if (wr_go) begin
            nxt_fp_status_control = xfer_req.wdata & fp_status_control_pkg::WRITABLE_MASK;
        end
        if (cmp_event.valid) begin
            nxt_fp_status_control[fp_status_control_pkg::BIT_NEG -: 4] = new_nzcv;
        end
        nxt_fp_status_control = nxt_fp_status_control | sticky_set;
    end

    // ==========================================================
    // Vector decode
    // ==========================================================
    logic [3:0] iter_w;
    logic [1:0] incr_w;
    logic       scalar_w;
    logic       single_ok_w;
    logic       double_ok_w;

    vector_combo_check u_combo (
        .len_code    (nxt_fp_status_control[fp_status_control_pkg::LEN_LO +: 3]),
        .stride_code (nxt_fp_status_control[fp_status_control_pkg::STRIDE_LO +: 2]),
        .iterations  (iter_w),
        .increment   (incr_w),
        .scalar_mode (scalar_w),
        .single_ok   (single_ok_w),
        .double_ok   (double_ok_w)
    );

    fp_status_control_pkg::fp_ctrl_t nxt_fp_ctrl;
    assign nxt_fp_ctrl.default_nan_enable = nxt_fp_status_control[fp_status_control_pkg::BIT_DNAN];
    assign nxt_fp_ctrl.flush_zero_enable  = nxt_fp_status_control[fp_status_control_pkg::BIT_FZ];
    assign nxt_fp_ctrl.round_mode = fp_status_control_pkg::round_mode_t'(
        nxt_fp_status_control[fp_status_control_pkg::RMODE_LO +: 2]);
    assign nxt_fp_ctrl.vector_iterations = iter_w;
    assign nxt_fp_ctrl.vector_increment  = incr_w;
    assign nxt_fp_ctrl.scalar_mode       = scalar_w;
    assign nxt_fp_ctrl.single_combo_ok   = single_ok_w;
    assign nxt_fp_ctrl.double_combo_ok   = double_ok_w;
    assign nxt_fp_ctrl.trap_en = {nxt_fp_status_control[fp_status_control_pkg::TRAP_HI_BIT],
                                  nxt_fp_status_control[fp_status_control_pkg::TRAP_LO +: 5]};

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fp_status_control_ff <= fp_status_control_pkg::RESET_VALUE;
            fp_ctrl_ff           <= '0;
            xfer_done_ff         <= 1'b0;
            undef_trap_ff        <= 1'b0;
            rdata_ff             <= 32'h00000000;
        end else begin
            fp_status_control_ff <= nxt_fp_status_control;
            fp_ctrl_ff           <= nxt_fp_ctrl;
            xfer_done_ff         <= granted;
            undef_trap_ff        <= refused;
            rdata_ff             <= rd_go ? fp_status_control_ff : 32'h00000000;
        end
    end

    assign xfer_done  = xfer_done_ff;
    assign undef_trap = undef_trap_ff;
    assign rdata      = rdata_ff;
    assign fp_ctrl    = fp_ctrl_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    user_access_a: assert property (hit && cp_enable && !privileged |=> xfer_done && !undef_trap)
        else $error("unprivileged access not granted");
    cmp_less_a: assert property (cmp_event.valid && cmp_event.result == fp_status_control_pkg::cmp_less
        |=> fp_status_control_ff[31:28] == 4'h8)
        else $error("less-than flags wrong");
    cmp_equal_a: assert property (cmp_event.valid && cmp_event.result == fp_status_control_pkg::cmp_equal
        |=> fp_status_control_ff[31:28] == 4'h6)
        else $error("equal flags wrong");
    cmp_carry_a: assert property (cmp_event.valid && cmp_event.result != fp_status_control_pkg::cmp_less
        |=> fp_status_control_ff[29])
        else $error("carry flag not set");
    cmp_unord_a: assert property (cmp_event.valid
        |=> fp_status_control_ff[28] == ($past(cmp_event.result) == fp_status_control_pkg::cmp_unordered))
        else $error("overflow flag wrong");
    mode_write_a: assert property (wr_go && !cmp_event.valid && !exc_valid
        |=> fp_ctrl.default_nan_enable == $past(xfer_req.wdata[25])
            && fp_ctrl.flush_zero_enable == $past(xfer_req.wdata[24])
            && fp_ctrl.round_mode == $past(xfer_req.wdata[23:22]))
        else $error("mode bits not taken from write");
    // Decoded controls follow the register on the same edge, except straight after reset
    flush_zero_a: assert property (!$past(srst)
        |-> fp_ctrl.flush_zero_enable == fp_status_control_ff[24])
        else $error("flush-to-zero out of step");
    iter_count_a: assert property (!$past(srst)
        |-> fp_ctrl.vector_iterations == {1'b0, fp_status_control_ff[18:16]} + 4'h1)
        else $error("iteration count wrong");
    scalar_mode_a: assert property (!$past(srst)
        |-> fp_ctrl.scalar_mode == (fp_status_control_ff[21:16] == 6'h00))
        else $error("scalar decode wrong");
    sticky_hold_a: assert property (fp_status_control_ff[0] && !wr_go |=> fp_status_control_ff[0])
        else $error("sticky flag lost");
    sticky_set_a: assert property (exc_valid && exc_flags.invalid_op |=> fp_status_control_ff[0])
        else $error("sticky flag not set");
    disabled_trap_a: assert property (hit && !cp_enable && !exc_valid
        |=> undef_trap && !xfer_done && $stable(fp_status_control_ff[27:0]))
        else $error("disabled access not trapped");
    reserved_zero_a: assert property ((fp_status_control_ff & ~fp_status_control_pkg::WRITABLE_MASK) == 32'h0)
        else $error("reserved bit set");

    cover_write_c:   cover property (wr_go ##1 xfer_done);
    cover_read_c:    cover property (rd_go ##1 xfer_done);
    cover_trap_c:    cover property (refused ##1 undef_trap);
    cover_unord_c:   cover property (cmp_event.valid && cmp_event.result == fp_status_control_pkg::cmp_unordered);
endmodule : fp_status_control_register

/* logic/fp_status_control_pkg.sv */
// Field layout, encodings and constants of the floating-point status/control word
package fp_status_control_pkg;

    localparam int unsigned WORD_W = 32;

    // Field positions
    localparam int unsigned BIT_NEG      = 31;
    localparam int unsigned BIT_ZERO     = 30;
    localparam int unsigned BIT_CARRY    = 29;
    localparam int unsigned BIT_OVFL     = 28;
    localparam int unsigned BIT_DNAN     = 25;
    localparam int unsigned BIT_FZ       = 24;
    localparam int unsigned RMODE_LO     = 22;
    localparam int unsigned STRIDE_LO    = 20;
    localparam int unsigned LEN_LO       = 16;
    localparam int unsigned TRAP_HI_BIT  = 15;
    localparam int unsigned TRAP_LO      = 8;
    localparam int unsigned STICKY_HI_BIT = 7;
    localparam int unsigned STICKY_LO    = 0;

    // Bits software may change; reserved positions [27:26], [19], [14:13], [6:5] read zero
    localparam logic [31:0] WRITABLE_MASK = 32'hF3F79F9F;
    localparam logic [31:0] RESET_VALUE   = 32'h00000000;

    // Coprocessor register select code of this register on the transfer port
    localparam logic [3:0] SEL_STATUS_CONTROL = 4'h1;

    localparam logic [2:0] LEN_SCALAR    = 3'h0;
    localparam logic [2:0] LEN_TWO       = 3'h1;
    localparam logic [2:0] LEN_FOUR      = 3'h3;
    localparam logic [1:0] STRIDE_ONE    = 2'h0;
    localparam logic [1:0] STRIDE_TWO    = 2'h3;

    typedef enum logic [1:0] {
        round_nearest     = 2'h0,
        round_plus_inf    = 2'h1,
        round_minus_inf   = 2'h2,
        round_toward_zero = 2'h3
    } round_mode_t;

    typedef enum logic [1:0] {
        cmp_less      = 2'h0,
        cmp_equal     = 2'h1,
        cmp_greater   = 2'h2,
        cmp_unordered = 2'h3
    } cmp_result_t;

    // Comparison result delivered by the datapath
    typedef struct packed {
        logic        valid;
        cmp_result_t result;
    } cmp_event_t;

    // Exception group order: input subnormal, 2'b00 gap, inexact, underflow, overflow,
    // divide-by-zero, invalid
    typedef struct packed {
        logic input_subnormal;
        logic inexact;
        logic underflow;
        logic overflow;
        logic divide_zero;
        logic invalid_op;
    } fp_exc_t;

    // Register transfer request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  sel;
        logic [31:0] wdata;
    } xfer_req_t;

    // Decoded controls handed to the datapath
    typedef struct packed {
        logic        default_nan_enable;
        logic        flush_zero_enable;
        round_mode_t round_mode;
        logic [3:0]  vector_iterations;
        logic [1:0]  vector_increment;
        logic        scalar_mode;
        logic        single_combo_ok;
        logic        double_combo_ok;
        fp_exc_t     trap_en;
    } fp_ctrl_t;

endpackage : fp_status_control_pkg

/* logic/vector_combo_check.sv */
// Decodes vector length/stride into iteration count, increment and legality
`timescale 1ns/1ps
module vector_combo_check (
    input  wire logic [2:0] len_code,
    input  wire logic [1:0] stride_code,
    output logic [3:0]      iterations,
    output logic [1:0]      increment,
    output logic            scalar_mode,
    output logic            single_ok,
    output logic            double_ok
);
    wire logic stride_one = (stride_code == fp_status_control_pkg::STRIDE_ONE);
    wire logic stride_two = (stride_code == fp_status_control_pkg::STRIDE_TWO);

    assign iterations  = {1'b0, len_code} + 4'h1;
    assign increment   = stride_two ? 2'h2 : 2'h1;
    assign scalar_mode = (len_code == fp_status_control_pkg::LEN_SCALAR) && stride_one;
    // Single precision: stride two only for lengths 2..4; length 1 with stride two illegal
    assign single_ok   = stride_one
                       || (stride_two && len_code != fp_status_control_pkg::LEN_SCALAR
                           && len_code <= fp_status_control_pkg::LEN_FOUR);
    // Double precision: stride two only at length 2, stride one up to length 4
    assign double_ok   = (stride_one && len_code <= fp_status_control_pkg::LEN_FOUR)
                       || (stride_two && len_code == fp_status_control_pkg::LEN_TWO);
endmodule : vector_combo_check

/* testbench/host_core_model.sv */
// Host core model issuing coprocessor register transfers
`timescale 1ns/1ps
module host_core_model (
    input  wire logic                        clk_sys,
    output fp_status_control_pkg::xfer_req_t xfer_req,
    output logic                             cp_enable,
    output logic                             privileged
);
    // ==========
    // Transfer driver
    initial begin
        xfer_req   = '0;
        cp_enable  = 1'b1;
        privileged = 1'b0;
    end

    // Stride two only on lengths 2 to 4, never on length one
    function automatic logic [1:0] stride_code(input logic [2:0] len, input logic two);
        return (two && len >= 3'h1 && len <= 3'h3) ? 2'h3 : 2'h0;
    endfunction : stride_code

    // Entered at a falling edge; the request is taken at the next rising edge
    task automatic do_xfer(input logic wr, input logic [3:0] sel, input logic [31:0] wd,
                           input logic en, input logic priv);
        cp_enable  = en;
        privileged = priv;
        xfer_req   = '{valid: 1'b1, write: wr, sel: sel, wdata: wd};
        @(negedge clk_sys);
    endtask : do_xfer

    // Released lines show the inverse of the last request
    task automatic idle;
        xfer_req = '{valid: 1'b0, write: ~xfer_req.write, sel: ~xfer_req.sel,
                     wdata: ~xfer_req.wdata};
        @(negedge clk_sys);
    endtask : idle
endmodule : host_core_model

/* testbench/fp_status_control_register_tb_top.sv */
// Self-checking bench of the floating-point status/control register
`timescale 1ns/1ps
module fp_status_control_register_tb_top;
    localparam logic [3:0] CMP_FLAGS [4] = '{4'h8, 4'h6, 4'h2, 4'h3};
    logic                              clk_sys;
    logic                              srst;
    logic                              cp_enable;
    logic                              privileged;
    fp_status_control_pkg::xfer_req_t  xfer_req;
    fp_status_control_pkg::cmp_event_t cmp_event;
    logic                              exc_valid;
    fp_status_control_pkg::fp_exc_t    exc_flags;
    logic                              xfer_done;
    logic                              undef_trap;
    logic [31:0]                       rdata;
    fp_status_control_pkg::fp_ctrl_t   fp_ctrl;
    int                                fails = 0;
    int                                n_tests = 0;
    int                                seed = 32'hcd00;
    logic [31:0]                       mirror;
    logic [33:0]                       exp_q[$];

    host_core_model i_host (.clk_sys(clk_sys), .xfer_req(xfer_req), .cp_enable(cp_enable),
                            .privileged(privileged));
    fp_status_control_register i_dut (.clk_sys(clk_sys), .srst(srst), .cp_enable(cp_enable),
        .privileged(privileged), .xfer_req(xfer_req), .cmp_event(cmp_event),
        .exc_valid(exc_valid), .exc_flags(exc_flags), .xfer_done(xfer_done),
        .undef_trap(undef_trap), .rdata(rdata), .fp_ctrl(fp_ctrl));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Notes the expected answer, then issues the transfer with a random mode
    task automatic access(input logic wr, input logic [31:0] wd, input logic en);
        logic p;
        p = 1'($random(seed));
        exp_q.push_back({en, ~en, (wr || !en) ? 32'h0 : mirror});
        if (en && wr) mirror = wd & fp_status_control_pkg::WRITABLE_MASK;
        i_host.do_xfer(wr, fp_status_control_pkg::SEL_STATUS_CONTROL, wd, en, p);
    endtask : access

    task automatic check_ctrl;
        fp_status_control_pkg::fp_ctrl_t e;
        fp_status_control_pkg::fp_ctrl_t g;
        logic                            s_ok;
        logic                            d_ok;
        g = fp_ctrl;
        s_ok = (mirror[21:20] == 2'h0) || (mirror[18:16] >= 3'h1 && mirror[18:16] <= 3'h3);
        d_ok = (mirror[21:20] == 2'h0 && mirror[18:16] <= 3'h3)
            || (mirror[21:20] == 2'h3 && mirror[18:16] == 3'h1);
        e = '{mirror[25], mirror[24], fp_status_control_pkg::round_mode_t'(mirror[23:22]),
              {1'b0, mirror[18:16]} + 4'h1, (mirror[21:20] == 2'h3) ? 2'h2 : 2'h1,
              mirror[21:16] == 6'h00, s_ok, d_ok, {mirror[15], mirror[12:8]}};
        check("fp_ctrl", 34'(e), 34'(g));
    endtask : check_ctrl

    task automatic cmp_pulse(input logic [1:0] r);
        cmp_event = '{1'b1, fp_status_control_pkg::cmp_result_t'(r)};
        mirror[31:28] = CMP_FLAGS[r];
        @(negedge clk_sys);
        cmp_event = '{1'b0, fp_status_control_pkg::cmp_result_t'(~r)};
    endtask : cmp_pulse

    task automatic exc_pulse(input logic [5:0] f);
        exc_valid = 1'b1;
        exc_flags = f;
        mirror[7] = mirror[7] | f[5];
        mirror[4:0] = mirror[4:0] | f[4:0];
        @(negedge clk_sys);
        exc_valid = 1'b0;
        exc_flags = ~f;
    endtask : exc_pulse

    // ==========
    // Response monitor
    always @(negedge clk_sys) begin
        if (xfer_done === 1'b1 || undef_trap === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error response expected none seen %h", rdata);
            end else begin
                check("response", exp_q.pop_front(), {xfer_done, undef_trap, rdata});
            end
        end
    end

    // ==========
    // Main sequence
    initial begin
        int          i;
        logic [31:0] wd;
        srst = 1'b1;
        cmp_event = '0;
        exc_valid = 1'b0;
        exc_flags = '0;
        mirror = 32'h0;
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        access(1'b0, 32'h0, 1'b1);
        i_host.idle();
        check_ctrl();
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            wd = 32'($random(seed)) & fp_status_control_pkg::WRITABLE_MASK;
            wd[23:22] = 2'(i);
            wd[18:16] = 3'(i);
            wd[21:20] = i_host.stride_code(3'(i), i >= 8);
            access(1'b1, wd, 1'b1);
            check_ctrl();
            access(1'b0, 32'h0, 1'b1);
            i_host.idle();
        end
        $display("test fields done");
        for (i = 0; i < 4; i++) begin
            cmp_pulse(2'(i));
            access(1'b0, 32'h0, 1'b1);
            i_host.idle();
        end
        $display("test compare done");
        for (i = 0; i < 2; i++) begin
            exc_pulse(6'($random(seed)));
            access(1'b0, 32'h0, 1'b1);
            i_host.idle();
        end
        access(1'b1, mirror & ~32'h0000009F, 1'b1);
        access(1'b0, 32'h0, 1'b1);
        i_host.do_xfer(1'b1, 4'h2, 32'hFFFFFFFF, 1'b1, 1'b0);
        access(1'b0, 32'h0, 1'b1);
        i_host.idle();
        $display("test sticky done");
        access(1'b1, 32'h01C00000, 1'b0);
        access(1'b0, 32'h0, 1'b0);
        access(1'b0, 32'h0, 1'b1);
        i_host.idle();
        $display("test disabled done");
        for (i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk_sys);
        if (exp_q.size() != 0) begin
            fails++;
            $display("Error responses expected %0d seen fewer", exp_q.size());
        end
        stop_test();
    end
endmodule : fp_status_control_register_tb_top
